// [bus_status_pkg.sv]
// constants for the maximum-mode bus cycle status encoder
// Overview of operation
// R1: status pin functions are used only while the mode strap reads low.
// R2: valid code in T4, T1, T2; passive 111 in T3 or ready wait state.
// R3: leaving passive during T4 marks the start of a new bus cycle.
// R4: returning to passive in T3 or a wait state marks the cycle end.
// R5: all three status outputs float while in hold acknowledge; code floats them only when the next state is ST_IDLE.
// R6: external controller derives every command strobe from the decoded status.
// R7: 000 inta,001 io rd,010 io wr,011 halt,100 code,101 mem rd,110 mem wr,111 passive.
// R8: addressed device drives ready high to finish; waits last while ready low.
// R9: status stays passive during idle bus states between cycles.
package bus_status_pkg;

    localparam int STATUS_W = 3;

    localparam logic [2:0] STATUS_INT_ACK = 3'h0;
    localparam logic [2:0] STATUS_IO_READ = 3'h1;
    localparam logic [2:0] STATUS_IO_WRITE = 3'h2;
    localparam logic [2:0] STATUS_HALT = 3'h3;
    localparam logic [2:0] STATUS_CODE_FETCH = 3'h4;
    localparam logic [2:0] STATUS_MEM_READ = 3'h5;
    localparam logic [2:0] STATUS_MEM_WRITE = 3'h6;
    localparam logic [2:0] STATUS_PASSIVE = 3'h7;

    // strap level that selects the maximum configuration
    localparam logic STRAP_MAX_LEVEL = 1'b0;
    localparam logic STRAP_RESET_LEVEL = 1'b1;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_T4 = 6'h02,
        ST_T1 = 6'h04,
        ST_T2 = 6'h08,
        ST_T3 = 6'h10,
        ST_TW = 6'h20
    } t_state_type;

endpackage

// [bus_status_encoder.sv]
// maximum-mode bus cycle status encoder with T-state sequencer
module bus_status_encoder
    import bus_status_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CONFIG_SELECT_STRAP_I,
    input wire logic READY_I,
    input wire logic HOLD_ACK_I,
    input wire logic CYCLE_REQ_I,
    input wire logic [2:0] CYCLE_TYPE_I,
    output logic [2:0] BUS_CYCLE_STATUS_O,
    output logic BUS_CYCLE_STATUS_OE_O,
    output logic CYCLE_ACK_O,
    output logic CYCLE_END_O,
    output logic BUS_BUSY_O
);

    logic strap_s1_reg;
    logic strap_s2_reg;
    logic strap_s3_reg;
    logic max_mode_reg;
    t_state_type state_reg;
    t_state_type state_next;
    logic [2:0] code_reg;
    logic [2:0] code_next;
    logic [2:0] status_next;
    logic oe_next;
    logic ack_next;
    logic end_next;
    logic take_req;

    // strap synchroniser, accepted once the last two stages agree
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            strap_s1_reg <= STRAP_RESET_LEVEL;
            strap_s2_reg <= STRAP_RESET_LEVEL;
            strap_s3_reg <= STRAP_RESET_LEVEL;
        end else begin
            strap_s1_reg <= CONFIG_SELECT_STRAP_I;
            strap_s2_reg <= strap_s1_reg;
            strap_s3_reg <= strap_s2_reg;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            max_mode_reg <= 1'b0;
        end else if (strap_s2_reg == strap_s3_reg) begin
            max_mode_reg <= (strap_s3_reg == STRAP_MAX_LEVEL); // [R1]
        end
    end

    // a new cycle is only taken in max mode, outside hold, with a real code
    assign take_req = CYCLE_REQ_I && max_mode_reg && !HOLD_ACK_I
        && (CYCLE_TYPE_I != STATUS_PASSIVE);

    always_comb begin
        state_next = state_reg;
        code_next = code_reg;
        status_next = STATUS_PASSIVE; // [R9]
        ack_next = 1'b0;
        end_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (take_req) begin
                    state_next = ST_T4;
                    code_next = CYCLE_TYPE_I;
                    status_next = CYCLE_TYPE_I; // [R3] [R7]
                    ack_next = 1'b1;
                end
            end
            ST_T4: begin
                if (BUS_CYCLE_STATUS_O != STATUS_PASSIVE) begin
                    state_next = ST_T1;
                    status_next = code_reg; // [R2]
                end else if (take_req) begin
                    state_next = ST_T4;
                    code_next = CYCLE_TYPE_I;
                    status_next = CYCLE_TYPE_I; // [R3] [R7]
                    ack_next = 1'b1;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_T1: begin
                state_next = ST_T2;
                status_next = code_reg; // [R2]
            end
            ST_T2: begin
                state_next = ST_T3;
                // ready at this edge ends the cycle in T3
                status_next = READY_I ? STATUS_PASSIVE : code_reg; // [R2] [R4] [R8]
                end_next = READY_I;
            end
            ST_T3, ST_TW: begin
                if (BUS_CYCLE_STATUS_O == STATUS_PASSIVE) begin
                    // final T4 of the cycle may announce the next one
                    state_next = ST_T4;
                    if (take_req) begin
                        code_next = CYCLE_TYPE_I;
                        status_next = CYCLE_TYPE_I; // [R3] [R7]
                        ack_next = 1'b1;
                    end
                end else begin
                    state_next = ST_TW;
                    status_next = READY_I ? STATUS_PASSIVE : code_reg; // [R2] [R4] [R8]
                    end_next = READY_I;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // outputs float in min mode or while the bus is handed over idle
    assign oe_next = max_mode_reg && !(HOLD_ACK_I && state_next == ST_IDLE); // [R1] [R5]

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE;
        end else if (!max_mode_reg) begin
            state_reg <= ST_IDLE; // [R1]
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            code_reg <= STATUS_PASSIVE;
        end else begin
            code_reg <= code_next;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            BUS_CYCLE_STATUS_O <= STATUS_PASSIVE;
            BUS_CYCLE_STATUS_OE_O <= 1'b0;
            CYCLE_ACK_O <= 1'b0;
            CYCLE_END_O <= 1'b0;
            BUS_BUSY_O <= 1'b0;
        end else if (!max_mode_reg) begin
            BUS_CYCLE_STATUS_O <= STATUS_PASSIVE;
            BUS_CYCLE_STATUS_OE_O <= 1'b0; // [R1]
            CYCLE_ACK_O <= 1'b0;
            CYCLE_END_O <= 1'b0;
            BUS_BUSY_O <= 1'b0;
        end else begin
            BUS_CYCLE_STATUS_O <= status_next;
            BUS_CYCLE_STATUS_OE_O <= oe_next;
            CYCLE_ACK_O <= ack_next;
            CYCLE_END_O <= end_next;
            BUS_BUSY_O <= (state_next != ST_IDLE);
        end
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_min_mode_float: assert property ( // [R1]
        !max_mode_reg |=> !BUS_CYCLE_STATUS_OE_O)
        else $error("status driven outside maximum mode");

    a_active_t1_t2: assert property ( // [R2]
        (state_reg == ST_T1 || state_reg == ST_T2) |-> BUS_CYCLE_STATUS_O != STATUS_PASSIVE)
        else $error("status passive in T1 or T2");

    a_code_held: assert property ( // [R2]
        (state_reg == ST_T4 && BUS_CYCLE_STATUS_O != STATUS_PASSIVE && max_mode_reg)
        |=> (state_reg == ST_T1 && $stable(BUS_CYCLE_STATUS_O))
        ##1 (state_reg == ST_T2 && $stable(BUS_CYCLE_STATUS_O)))
        else $error("cycle code not held through T1 and T2");

    a_start_in_t4: assert property ( // [R3]
        CYCLE_ACK_O |-> state_reg == ST_T4 && BUS_CYCLE_STATUS_O != STATUS_PASSIVE)
        else $error("cycle start not signalled in T4");

    a_end_passive: assert property ( // [R4]
        CYCLE_END_O |-> BUS_CYCLE_STATUS_O == STATUS_PASSIVE
        && (state_reg == ST_T3 || state_reg == ST_TW))
        else $error("cycle end not passive in T3 or wait");

    a_wait_ready: assert property ( // [R8]
        (state_reg == ST_TW && BUS_CYCLE_STATUS_O != STATUS_PASSIVE && READY_I
        && max_mode_reg) |=> CYCLE_END_O && state_reg == ST_TW)
        else $error("ready in wait state did not end the cycle");

    a_hold_float: assert property ( // [R5]
        (state_reg == ST_IDLE && HOLD_ACK_I && max_mode_reg) |=> !BUS_CYCLE_STATUS_OE_O)
        else $error("status driven during hold acknowledge");

    a_code_mapping: assert property ( // [R7]
        CYCLE_ACK_O |-> BUS_CYCLE_STATUS_O == $past(CYCLE_TYPE_I))
        else $error("status code differs from requested cycle type");

    a_idle_passive: assert property ( // [R9]
        state_reg == ST_IDLE |-> BUS_CYCLE_STATUS_O == STATUS_PASSIVE)
        else $error("status not passive while idle");

    a_ack_one_cycle: assert property ( // [R3]
        CYCLE_ACK_O |=> !CYCLE_ACK_O)
        else $error("cycle start pulse longer than one clock");

    a_final_t4: assert property ( // [R4]
        (CYCLE_END_O && max_mode_reg) |=> state_reg == ST_T4
        && (CYCLE_ACK_O || BUS_CYCLE_STATUS_O == STATUS_PASSIVE))
        else $error("cycle end not followed by a final T4");

    a_hold_no_start: assert property ( // [R5]
        (state_reg == ST_IDLE && HOLD_ACK_I) |=> !CYCLE_ACK_O)
        else $error("cycle started during hold acknowledge");

    c_wait_cycle: cover property (
        state_reg == ST_TW ##1 CYCLE_END_O);
    c_back_to_back: cover property (
        CYCLE_END_O ##1 CYCLE_ACK_O);
    c_hold_release: cover property (
        BUS_CYCLE_STATUS_OE_O ##1 !BUS_CYCLE_STATUS_OE_O ##[1:20] BUS_CYCLE_STATUS_OE_O);
    c_max_mode_entry: cover property (
        $rose(max_mode_reg));

endmodule

// [bus_ctrl_model.sv]
// behavioural external bus controller watching the status lines
module bus_ctrl_model
    import bus_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] status_i,
    input wire logic oe_i,
    input wire logic [3:0] wait_cnt_i,
    output logic ready_o,
    output logic rd_cmd_o,
    output logic [7:0] starts_o,
    output logic [7:0] ends_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_now;
    logic prev_reg;
    logic [7:0] cnt_reg;
    assign busy_now = oe_i && (status_i !== STATUS_PASSIVE);
    assign rd_cmd_o = busy_now && (status_i inside {3'h0, 3'h1, 3'h4, 3'h5});
    assign ready_o = (cnt_reg >= 8'(wait_cnt_i + 4'h2));
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_reg <= 1'b0;
            cnt_reg <= 8'h00;
            starts_o <= 8'h00;
            ends_o <= 8'h00;
        end else begin
            prev_reg <= busy_now;
            cnt_reg <= busy_now ? cnt_reg + 8'h01 : 8'h00;
            if (busy_now && !prev_reg) starts_o <= starts_o + 8'h01;
            if (!busy_now && prev_reg) ends_o <= ends_o + 8'h01;
        end
    end
endmodule

// [test_max_mode_bus_status_encoder.sv]
// testbench for the bus cycle status encoder
module test_max_mode_bus_status_encoder
    import bus_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, ready, hold = 1'b0, req = 1'b0;
    logic [2:0] typ = 3'h7, st;
    logic oe, ack, cend, busy, rd_cmd;
    logic [3:0] waits = 4'h0;
    logic [7:0] starts, ends;
    int errors = 0, samples_checked = 0;
    always #50 clk = ~clk;
    bus_status_encoder bus_status_encoder_inst (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
        .CONFIG_SELECT_STRAP_I(strap), .READY_I(ready), .HOLD_ACK_I(hold), .CYCLE_REQ_I(req),
        .CYCLE_TYPE_I(typ), .BUS_CYCLE_STATUS_O(st), .BUS_CYCLE_STATUS_OE_O(oe),
        .CYCLE_ACK_O(ack), .CYCLE_END_O(cend), .BUS_BUSY_O(busy));
    bus_ctrl_model bus_ctrl_model_inst (.clk_i(clk), .reset_n_i(rst_n), .status_i(st),
        .oe_i(oe), .wait_cnt_i(waits), .ready_o(ready), .rd_cmd_o(rd_cmd), .starts_o(starts),
        .ends_o(ends));
    task print_verdict();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task do_reset();
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task run_cycle(input logic [2:0] t, input logic [3:0] w);
        int n;
        logic rd_exp;
        waits = w;
        req = 1'b1;
        typ = t;
        n = 0;
        while (ack !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (ack !== 1'b1) begin
            errors++;
            print_verdict();
        end
        check("status at start", st, t);
        rd_exp = (t == STATUS_INT_ACK) || (t == STATUS_IO_READ)
            || (t == STATUS_CODE_FETCH) || (t == STATUS_MEM_READ);
        check("read strobe", rd_cmd, rd_exp);
        check("ends at start", ends, starts);
        req = 1'b0;
        n = 0;
        while (cend !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
            if (cend !== 1'b1) check("status held", st, t);
        end
        if (cend !== 1'b1) begin
            errors++;
            print_verdict();
        end
        check("cycle length", n[7:0], 8'(3 + w));
        check("status at end", st, STATUS_PASSIVE);
        check("starts at end", starts, 8'(ends + 8'h01));
        $display("cycle %h waits %0d done", t, w);
    endtask
    task test_min_mode();
        do_reset();
        req = 1'b1;
        typ = STATUS_MEM_READ;
        repeat (6) @(negedge clk);
        check("min oe", oe, 1'b0);
        check("min busy", busy, 1'b0);
        req = 1'b0;
        strap = STRAP_MAX_LEVEL;
        do_reset();
        check("max oe", oe, 1'b1);
        check("idle status", st, STATUS_PASSIVE);
        $display("mode test done");
    endtask
    task test_hold();
        req = 1'b1;
        typ = STATUS_PASSIVE;
        repeat (4) @(negedge clk);
        check("passive request", busy, 1'b0);
        check("idle status", st, STATUS_PASSIVE);
        hold = 1'b1;
        typ = STATUS_IO_READ;
        repeat (4) @(negedge clk);
        check("hold oe", oe, 1'b0);
        check("hold busy", busy, 1'b0);
        hold = 1'b0;
        run_cycle(STATUS_IO_READ, 4'h0);
        check("oe after hold", oe, 1'b1);
        $display("hold test done");
    endtask
    initial begin
        test_min_mode();
        for (int i = 0; i < 7; i++) run_cycle(3'(i), 4'h0);
        run_cycle(STATUS_MEM_WRITE, 4'h3);
        test_hold();
        print_verdict();
    end
endmodule
